// ==== fbp_regs.svh ====
// flash block protection: address geometry and encodings
// assumes byte addresses on every access port
`ifndef FBP_REGS_SVH
`define FBP_REGS_SVH

// ****************************************************
// geometry
// ****************************************************
`define FBP_ADDR_W        15
`define FBP_BLK_LSB       10
`define FBP_UNIT_LSB      11
`define FBP_NUM_UNITS     16
`define FBP_NUM_BLKS      32
`define FBP_WORDS_PER_BLK 256
`define FBP_WORD_W        32
`define FBP_ERASED_WORD   32'hFFFF_FFFF

// ****************************************************
// protection encodings, two bits per unit
// ****************************************************
`define FBP_PROT_OPEN     2'h0
`define FBP_PROT_RO       2'h1
`define FBP_PROT_XO       2'h2
`define FBP_PROT_RSVD     2'h3
`define FBP_PROT_RESET    32'h0000_0000

`endif

// ==== fbp_pkg.sv ====
// flash block protection package: shared types
// assumes fbp_regs.svh on the include path
`include "fbp_regs.svh"

package fbp_pkg;
    typedef logic [1:0] fbp_prot_t;
    typedef enum logic [1:0] {
        FBP_SRC_IFETCH,
        FBP_SRC_DATA,
        FBP_SRC_DEBUG
    } fbp_src_e;
    typedef enum logic [1:0] {
        FBP_OP_READ,
        FBP_OP_PROG,
        FBP_OP_ERASE
    } fbp_op_e;
endpackage

// ==== fbp_erase_if.sv ====
// flash block protection: link between gate and erase sequencer
// assumes one clock shared by both ends
`timescale 1ns/10ps
`default_nettype none

interface fbp_erase_if;
    logic       start;
    logic       busy;
    logic       wr_en;
    logic [7:0] wr_idx;
    modport gate (output start, input busy, input wr_en, input wr_idx);
    modport seq  (input start, output busy, output wr_en, output wr_idx);
endinterface

`default_nettype wire

// ==== fbp_erase_seq.sv ====
// flash block protection: erase sequencer, one word per clock
// assumes start only while busy is low
`timescale 1ns/10ps
`default_nettype none
`include "fbp_regs.svh"

module fbp_erase_seq
    import fbp_pkg::*;
(
    input  wire logic   clk_sys,
    input  wire logic   reset_n,
    fbp_erase_if.seq    ers
);
    logic       busy_q;
    logic [7:0] idx_q;

    // ****************************************************
    // walk the block writing erased words
    // ****************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            idx_q  <= 8'h00;
        end else if (!busy_q && ers.start) begin
            busy_q <= 1'b1;
            idx_q  <= 8'h00;
        end else if (busy_q) begin
            idx_q <= idx_q + 8'h01;
            if (idx_q == 8'(`FBP_WORDS_PER_BLK - 1)) begin
                busy_q <= 1'b0;
            end
        end
    end

    assign ers.busy   = busy_q;
    assign ers.wr_en  = busy_q;
    assign ers.wr_idx = idx_q;
endmodule

`default_nettype wire

// ==== fbp_gate.sv ====
// flash block protection: 32 KB array with per-unit access gate
// assumes requests come from logic on clk_sys, one per cycle when ready
// assumes program and erase need no cell timing beyond one word per clock
//
// Behaviour
// - array holds 32 KB; beyond is out
// - 1 KB blocks erase independently
// - erased block reads all ones
// - protection per 2 KB unit pair
// - modes: open, read-only, execute-only
// - read-only units refuse program and erase
// - execute-only units refuse program and erase
// - execute-only returns data to fetches only
// - execute-only denies data and debug reads
`timescale 1ns/10ps
`default_nettype none
`include "fbp_regs.svh"

module fbp_gate
    import fbp_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic         req_valid,
    output logic              req_ready,
    input  wire fbp_src_e     req_src,
    input  wire fbp_op_e      req_op,
    input  wire logic [31:0]  req_addr,
    input  wire logic [31:0]  req_wdata,
    input  wire logic         prot_wr,
    input  wire logic [3:0]   prot_unit,
    input  wire fbp_prot_t    prot_val,
    output logic [31:0]       prot_map,
    output logic              rsp_valid,
    output logic [31:0]       rsp_rdata,
    output logic              rsp_denied,
    output logic              rsp_range_err,
    output logic              erase_busy
);
    // ****************************************************
    // storage and protection state
    // ****************************************************
    // 32 KB held as 32-bit words; byte lanes are not modelled
    logic [`FBP_WORD_W-1:0]  mem_q [`FBP_NUM_BLKS*`FBP_WORDS_PER_BLK];
    logic [31:0]             prot_q;
    logic                    rsp_valid_q;
    logic [31:0]             rsp_rdata_q;
    logic                    rsp_denied_q;
    logic                    rsp_range_q;
    logic [4:0]              ers_blk_q;

    // ****************************************************
    // erase sequencer link
    // ****************************************************
    // the gate starts a run and steers its writes; the sequencer only counts words
    fbp_erase_if ers();

    fbp_erase_seq u_seq (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .ers     (ers)
    );

    // ****************************************************
    // decode helpers
    // ****************************************************
    // unit index of an address
    function automatic logic [3:0] unit_of(input logic [31:0] a);
        unit_of = a[`FBP_ADDR_W-1:`FBP_UNIT_LSB];
    endfunction

    // two-bit setting of one unit out of the packed map
    function automatic fbp_prot_t prot_of(input logic [31:0] map, input logic [3:0] u);
        prot_of = map[{u, 1'b0} +: 2];
    endfunction

    // ****************************************************
    // per-unit protection decode
    // ****************************************************
    // one flag pair per 2 KB unit, shared by both of its 1 KB blocks
    logic [`FBP_NUM_UNITS-1:0] unit_wr_lock;
    logic [`FBP_NUM_UNITS-1:0] unit_xo;

    // a generate loop keeps the sixteen decoders identical
    for (genvar u = 0; u < `FBP_NUM_UNITS; u++) begin : g_unit
        // anything but open refuses program and erase
        assign unit_wr_lock[u] = (prot_of(prot_q, 4'(u)) != `FBP_PROT_OPEN);
        // execute-only hides contents from all but fetches
        assign unit_xo[u]      = (prot_of(prot_q, 4'(u)) == `FBP_PROT_XO);
    end

    // ****************************************************
    // request decode
    // ****************************************************
    logic        in_range;
    logic [3:0]  cur_unit;
    logic        wr_block;
    logic        rd_block;
    logic        is_read;
    logic        is_prog;
    logic        is_erase;
    logic        deny;
    logic        take;
    logic        go;
    logic [12:0] widx;

    // addresses past 32 KB never reach the array
    assign in_range = (req_addr[31:`FBP_ADDR_W] == '0);
    // both 1 KB blocks of a unit share one setting
    assign cur_unit = unit_of(req_addr);
    // the reserved code never reaches the map, so only three settings decode
    assign wr_block = unit_wr_lock[cur_unit];
    assign rd_block = unit_xo[cur_unit] && (req_src != FBP_SRC_IFETCH);
    // operation decode
    assign is_read  = (req_op == FBP_OP_READ);
    assign is_prog  = (req_op == FBP_OP_PROG);
    assign is_erase = (req_op == FBP_OP_ERASE);
    // writes of either kind share one lock; reads only meet execute-only
    assign deny     = is_read ? rd_block : wr_block;
    // stall while erasing so reads never see a half-cleared block
    assign req_ready = !ers.busy;
    // nothing is taken while reset is held, so a stray request cannot touch the array
    assign take      = req_valid && req_ready && reset_n;
    // passed both the range and the protection check
    assign go        = take && in_range && !deny;
    // word index within the array; the two byte bits are ignored
    assign widx      = req_addr[`FBP_ADDR_W-1:2];

    // status outputs mirror internal state
    assign erase_busy = ers.busy;
    assign prot_map   = prot_q;

    // ****************************************************
    // protection settings; open or tighten, reserved code ignored
    // ****************************************************
    // no lock bit: a unit may be loosened as freely as tightened
    // a write governs requests from the next edge on
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prot_q <= `FBP_PROT_RESET;
        end else if (prot_wr && (prot_val != `FBP_PROT_RSVD)) begin
            prot_q[{prot_unit, 1'b0} +: 2] <= prot_val;
        end
    end

    // ****************************************************
    // erase launch, one 1 KB block
    // ****************************************************
    // the block is kept for the whole run, so the request address need not be held while req_ready stays low
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ers_blk_q <= 5'h00;
        end else if (go && is_erase) begin
            ers_blk_q <= req_addr[`FBP_ADDR_W-1:`FBP_BLK_LSB];
        end
    end

    // start pulse; the sequencer ignores it while already busy
    assign ers.start = go && is_erase;

    // ****************************************************
    // array writes: programming clears bits, erase sets all
    // ****************************************************
    // the array has no reset, so contents survive reset as flash cells would
    always_ff @(posedge clk_sys) begin
        if (ers.wr_en) begin
            mem_q[{ers_blk_q, ers.wr_idx}] <= `FBP_ERASED_WORD;
        end else if (go && is_prog) begin
            mem_q[widx] <= mem_q[widx] & req_wdata;
        end
    end

    // ****************************************************
    // response, one cycle after the request is taken
    // ****************************************************
    // a request taken at one edge shows its answer right after that same edge,
    // for that one cycle only; an erase answers at once and then keeps
    // req_ready low for the 256 cycles of its run
    // every taken request answers exactly once, denied or not
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= take;
        end
    end

    // protection refusals count only inside the array
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rsp_denied_q <= 1'b0;
        end else begin
            rsp_denied_q <= take && in_range && deny;
        end
    end

    // out-of-range requests have no effect but this flag
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rsp_range_q <= 1'b0;
        end else begin
            rsp_range_q <= take && !in_range;
        end
    end

    // denied reads return zeros so no stored bit leaks
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rsp_rdata_q <= 32'h0000_0000;
        end else if (go && is_read) begin
            rsp_rdata_q <= mem_q[widx];
        end else begin
            rsp_rdata_q <= 32'h0000_0000;
        end
    end

    assign rsp_valid     = rsp_valid_q;
    assign rsp_rdata     = rsp_rdata_q;
    assign rsp_denied    = rsp_denied_q;
    assign rsp_range_err = rsp_range_q;
endmodule

`default_nettype wire

// ==== fbp_gate_assertions.sv ====
// flash block protection: port-level checks on the access gate
// assumes bind onto fbp_gate, one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
`include "fbp_regs.svh"

module fbp_gate_assertions
    import fbp_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire fbp_src_e    req_src,
    input wire fbp_op_e     req_op,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] prot_map,
    input wire logic        rsp_valid,
    input wire logic [31:0] rsp_rdata,
    input wire logic        rsp_denied,
    input wire logic        rsp_range_err,
    input wire logic        erase_busy
);
    // ****************************************************
    // checks
    // ****************************************************
    // setting of the addressed unit; a prot_wr lands one edge later, so the map is current
    wire fbp_prot_t cur = prot_map[{req_addr[14:11], 1'b0} +: 2];
    wire logic      tk  = req_valid && req_ready;
    wire logic      wr  = tk && req_addr < 32'h0000_8000 && req_op != FBP_OP_READ;
    wire logic      xr  = tk && req_addr < 32'h0000_8000 && req_op == FBP_OP_READ && cur == `FBP_PROT_XO;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence ers_take; wr && req_op == FBP_OP_ERASE && cur == `FBP_PROT_OPEN; endsequence
    // only the ends of the run are sampled, which keeps the check cheap
    sequence ers_run; erase_busy ##255 erase_busy ##1 !erase_busy; endsequence
    take_answered_a: assert property (tk |=> rsp_valid) else $error("no response after take");
    range_flag_a: assert property (tk && req_addr >= 32'h0000_8000 |=> rsp_range_err) else $error("range");
    erase_length_a: assert property (ers_take |=> ers_run) else $error("erase length wrong");
    open_write_a: assert property (wr && cur == `FBP_PROT_OPEN |=> !rsp_denied) else $error("open denied");
    ro_refuse_a: assert property (wr && cur == `FBP_PROT_RO |=> rsp_denied) else $error("ro write taken");
    xo_refuse_a: assert property (wr && cur == `FBP_PROT_XO |=> rsp_denied) else $error("xo write taken");
    xo_fetch_a: assert property (xr && req_src == FBP_SRC_IFETCH |=> !rsp_denied) else $error("fetch denied");
    xo_hide_a: assert property (xr && req_src != FBP_SRC_IFETCH |=> rsp_denied && rsp_rdata == 32'h0000_0000)
        else $error("xo data leaked");
endmodule

bind fbp_gate fbp_gate_assertions chk_u (.clk_sys, .reset_n, .req_valid, .req_ready, .req_src, .req_op,
    .req_addr, .prot_map, .rsp_valid, .rsp_rdata, .rsp_denied, .rsp_range_err, .erase_busy);

`default_nettype wire

// ==== fbp_cpu_model.sv ====
// flash block protection: processor and debugger request side
// assumes requests start just after a clock edge
`timescale 1ns/10ps
`default_nettype none

module fbp_cpu_model
    import fbp_pkg::*;
(
    input  wire logic    clk_sys,
    input  wire logic    req_ready,
    output var logic     req_valid,
    output var fbp_src_e req_src,
    output var fbp_op_e  req_op,
    output var logic [31:0] req_addr,
    output var logic [31:0] req_wdata
);
    // idle bus at time zero
    initial begin
        req_valid = 0;
        req_src = FBP_SRC_DATA;
        req_op = FBP_OP_READ;
        req_addr = '0;
        req_wdata = '0;
    end
    // hold until taken; released address and write data flip so stale values never pass
    task automatic access(input fbp_src_e s, input fbp_op_e o, input logic [31:0] a, input logic [31:0] d);
        req_valid = 1;
        req_src = s;
        req_op = o;
        req_addr = a;
        req_wdata = d;
        for (int n = 0; !req_ready && n < 300; n++) @(posedge clk_sys) #1;
        @(posedge clk_sys) #1;
        req_valid = 0;
        req_addr = ~a;
        req_wdata = ~d;
    endtask
endmodule

`default_nettype wire

// ==== flash_block_protection_bench.sv ====
// flash block protection: self-checking bench for the gate
// assumes the checker binds itself; erases run 256 cycles
`timescale 1ns/10ps
`default_nettype none

module flash_block_protection_bench
    import fbp_pkg::*;
;
    logic        clk_sys = 0, reset_n = 0, prot_wr = 0, req_valid, req_ready, rsp_valid, rsp_denied, rsp_range_err;
    logic        erase_busy;
    fbp_src_e    req_src;
    fbp_op_e     req_op;
    logic [31:0] req_addr, req_wdata, prot_map, rsp_rdata;
    logic [3:0]  prot_unit = 0;
    fbp_prot_t   prot_val = 0;
    int          err_total = 0, cmp_count = 0;
    localparam fbp_src_e F = FBP_SRC_IFETCH, D = FBP_SRC_DATA, G = FBP_SRC_DEBUG;
    localparam fbp_op_e  R = FBP_OP_READ, P = FBP_OP_PROG, E = FBP_OP_ERASE;
    typedef struct packed {logic pw; logic [3:0] pu; fbp_prot_t pv; fbp_src_e s; fbp_op_e o;
        logic [15:0] a; logic [31:0] wd; logic den; logic rng; logic [31:0] rd;} fbp_row_s;
    // optional protection write, request, then expected denial, range flag and read data
    fbp_row_s rows [19] = '{'{0,0,0,D,E,16'h0000,'0,0,0,'0}, '{0,0,0,D,P,16'h0000,32'hA5A5_0F0F,0,0,'0},
        '{0,0,0,D,E,16'h0400,'0,0,0,'0}, '{0,0,0,D,R,16'h0000,'0,0,0,32'hA5A5_0F0F},
        '{0,0,0,G,R,16'h0404,'0,0,0,32'hFFFF_FFFF}, '{0,0,0,D,E,16'h0C00,'0,0,0,'0},
        '{0,0,0,D,P,16'h0C00,32'hAAAA_5555,0,0,'0}, '{0,0,0,D,E,16'h1400,'0,0,0,'0},
        '{0,0,0,D,P,16'h1404,32'h1234_5678,0,0,'0}, '{1,1,1,D,E,16'h0800,'0,1,0,'0},
        '{0,0,0,D,P,16'h0C00,'0,1,0,'0}, '{0,0,0,D,R,16'h0C00,'0,0,0,32'hAAAA_5555},
        '{1,2,2,G,R,16'h1404,'0,1,0,'0}, '{0,0,0,D,R,16'h1404,'0,1,0,'0},
        '{0,0,0,F,R,16'h1404,'0,0,0,32'h1234_5678}, '{0,0,0,D,P,16'h1000,'0,1,0,'0},
        '{0,0,0,D,E,16'h1400,'0,1,0,'0}, '{0,0,0,D,R,16'h8000,'0,0,1,'0},
        '{1,2,0,D,R,16'h1404,'0,0,0,32'h1234_5678}};

    fbp_gate dut_u (.clk_sys, .reset_n, .req_valid, .req_ready, .req_src, .req_op, .req_addr, .req_wdata,
        .prot_wr, .prot_unit, .prot_val, .prot_map, .rsp_valid, .rsp_rdata, .rsp_denied, .rsp_range_err,
        .erase_busy);
    fbp_cpu_model cpu_u (.clk_sys, .req_ready, .req_valid, .req_src, .req_op, .req_addr, .req_wdata);

    // ****************************************************
    // clock, checking and verdict
    // ****************************************************
    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // four erase runs of about 260 cycles each, plus one cut short, finish far inside this limit
    initial begin
        #20000;
        err_total++;
        summarize();
    end

    // ****************************************************
    // scenarios
    // ****************************************************
    // table first, then an erase cut short by reset
    initial begin
        repeat (2) @(posedge clk_sys);
        #1 reset_n = 1;
        @(posedge clk_sys) #1;
        for (int i = 0; i < 19; i++) begin
            if (rows[i].pw) begin
                prot_wr = 1;
                prot_unit = rows[i].pu;
                prot_val = rows[i].pv;
                @(posedge clk_sys) #1;
                prot_wr = 0;
                chk("prot_map", {30'h0, prot_map[{rows[i].pu, 1'b0} +: 2]}, {30'h0, rows[i].pv});
            end
            cpu_u.access(rows[i].s, rows[i].o, {16'h0000, rows[i].a}, rows[i].wd);
            chk("rsp_valid", {31'h0, rsp_valid}, 32'h0000_0001);
            chk("rsp_denied", {31'h0, rsp_denied}, {31'h0, rows[i].den});
            chk("rsp_range_err", {31'h0, rsp_range_err}, {31'h0, rows[i].rng});
            if (rows[i].o == R && !rows[i].rng) chk("rsp_rdata", rsp_rdata, rows[i].rd);
            @(posedge clk_sys) #1;
        end
        // reserved code is ignored and leaves the unit as it was
        prot_wr = 1;
        prot_unit = 4'h1;
        prot_val = 2'h3;
        @(posedge clk_sys) #1;
        prot_wr = 0;
        chk("prot_map", {30'h0, prot_map[3:2]}, 32'h0000_0001);
        cpu_u.access(D, E, 32'h0000_0000, 32'h0000_0000);
        chk("erase_busy", {31'h0, erase_busy}, 32'h0000_0001);
        reset_n = 0;
        repeat (2) @(posedge clk_sys);
        #1 reset_n = 1;
        chk("erase_busy", {31'h0, erase_busy}, 32'h0000_0000);
        chk("req_ready", {31'h0, req_ready}, 32'h0000_0001);
        chk("prot_map", prot_map, 32'h0000_0000);
        chk("rsp_valid", {31'h0, rsp_valid}, 32'h0000_0000);
        // first request right after release; the array kept its contents
        cpu_u.access(G, R, 32'h0000_0404, 32'h0000_0000);
        chk("rsp_valid", {31'h0, rsp_valid}, 32'h0000_0001);
        chk("rsp_rdata", rsp_rdata, 32'hFFFF_FFFF);
        summarize();
    end
endmodule

`default_nettype wire
